// >>> hdl/seeb_device.sv
// Overview of operation
// - detect start and stop while clock high
// - stop after write data starts programming
// - standby after stop or finished programming
// - receiver pulls data low on ninth clock
// - data stable while clock high, msb first
// - command bits 3..1 must match selects
// - command bit 0 chooses write or read
// - ignore commands with wrong type code
// - master sends high then low address
// - read continues while master acknowledges
// - counter advances per written or read byte
// - acknowledge command, addresses and data byte
// - erase selected bytes, then write buffer
// - programming finishes within 8 ms
// - page buffer holds up to 32 bytes
// - write counter wraps in its low five address bits only
// - untouched page bytes are not programmed
// - write protect high suppresses programming
// - no command acknowledge while programming
// - counter ends at last entered byte
// - repeated start aborts write, then read
// - sample on rising, change after falling
module seeb_device
   import seeb_pkg::*;
#(
   parameter int PROG_CYCLES_P = PROG_CYCLES
) (
   input wire logic core_clk, // system clock for the programming timer
   input wire logic reset_n, // async reset, active low
   input wire logic chip_select_pin_0, // hard-wired select
   input wire logic chip_select_pin_1, // hard-wired select
   input wire logic chip_select_pin_2, // hard-wired select
   input wire logic write_protect, // high blocks programming
   output logic prog_busy, // erase/write cycle running
   seeb_bus_if.dev bus // two-wire bus
);

   localparam int CW = $clog2(PROG_CYCLES_P + 1);

   logic [7:0] mem [MEM_BYTES];
   logic [7:0] page_buf [PAGE_BYTES];

   // ****************************************************************
   // bus conditions, clocked by the data line itself
   // ****************************************************************
   logic start_tog;
   logic start_ack;
   logic stop_tog;
   logic stop_ack;

   // the clock is idle between frames, so conditions are caught on data edges
   always_ff @(negedge bus.sda or negedge reset_n) begin
      if (!reset_n) begin
         start_tog <= 1'b0;
      end else if (bus.scl) begin
         start_tog <= ~start_tog;
      end
   end

   always_ff @(posedge bus.sda or negedge reset_n) begin
      if (!reset_n) begin
         stop_tog <= 1'b0;
      end else if (bus.scl) begin
         stop_tog <= ~stop_tog;
      end
   end

   // ****************************************************************
   // link side, on the serial clock
   // ****************************************************************
   seeb_dev_state_e state;
   seeb_dev_state_e next_state;
   logic next_ack;
   logic [3:0] bitcnt;
   logic [7:0] shreg;
   logic [7:0] tx;
   logic [ADDR_W-1:0] addr;
   logic inc_pending;
   logic ack_now;
   logic oe_n;
   logic [PAGE_BYTES-1:0] valid;
   logic [2:0] cs_m;
   logic [2:0] cs_s;
   logic busy_m;
   logic busy_s;

   wire start_seen = start_tog != start_ack;
   wire [7:0] byte_in = {shreg[6:0], bus.sda};
   wire ack_slot = bitcnt == ACK_SLOT;
   wire byte_done = !start_seen && bitcnt == LAST_DATA_BIT;
   wire inc_bit = !start_seen && stop_tog == stop_ack && bitcnt == 4'h1;
   wire type_ok = byte_in[7:4] == DEV_TYPE_CODE;
   wire sel_ok = byte_in[3:1] == cs_s;
   wire cmd_hit = type_ok && sel_ok && !busy_s;
   wire [7:0] mem_rd = mem[addr];
   wire [ADDR_W-1:0] addr_inc = addr + 12'h001;
   wire [ADDR_W-1:0] page_inc = {addr[11:5], addr[4:0] + 5'h01};
   wire read_cmd = byte_done && state == DEV_CMD && cmd_hit && byte_in[0];
   wire read_more = !start_seen && ack_slot && state == DEV_READ && !bus.sda && !ack_now;

   always_ff @(posedge bus.scl or negedge reset_n) begin
      if (!reset_n) begin
         cs_m <= 3'h0;
         cs_s <= 3'h0;
         busy_m <= 1'b0;
         busy_s <= 1'b0;
         stop_ack <= 1'b0;
      end else begin
         stop_ack <= stop_tog;
         cs_m <= {chip_select_pin_2, chip_select_pin_1, chip_select_pin_0};
         cs_s <= cs_m;
         busy_m <= prog_busy;
         busy_s <= busy_m;
      end
   end

   always_comb begin
      next_state = state;
      next_ack = 1'b1;
      unique case (state)
         DEV_CMD: begin
            next_state = !cmd_hit ? DEV_IGNORE : byte_in[0] ? DEV_READ : DEV_AHI;
            next_ack = cmd_hit;
         end
         DEV_AHI: next_state = DEV_ALO;
         DEV_ALO: next_state = DEV_WDATA;
         DEV_WDATA: next_state = DEV_WDATA;
         DEV_READ: next_ack = 1'b0;
         DEV_IGNORE: next_ack = 1'b0;
         default: begin
            next_state = DEV_IGNORE;
            next_ack = 1'b0;
         end
      endcase
   end

   // bits are taken on the rising edge
   always_ff @(posedge bus.scl or negedge reset_n) begin
      if (!reset_n) begin
         state <= DEV_IGNORE;
         bitcnt <= 4'h0;
         shreg <= 8'h00;
         ack_now <= 1'b0;
         start_ack <= 1'b0;
      end else if (start_seen) begin
         start_ack <= start_tog;
         state <= DEV_CMD;
         bitcnt <= 4'h1;
         shreg <= {7'h00, bus.sda};
         ack_now <= 1'b0;
      end else if (ack_slot) begin
         bitcnt <= 4'h0;
         ack_now <= 1'b0;
         if (state == DEV_READ && bus.sda) begin
            state <= DEV_IGNORE;
         end
      end else begin
         bitcnt <= bitcnt + 4'h1;
         shreg <= byte_in;
         if (byte_done) begin
            state <= next_state;
            ack_now <= next_ack;
         end
      end
   end

   // counter moves on the second bit of the following byte: a stop also
   // raises the clock once, so it must not move the counter
   always_ff @(posedge bus.scl or negedge reset_n) begin
      if (!reset_n) begin
         addr <= ADDR_RST;
         tx <= ERASED_BYTE;
         inc_pending <= 1'b0;
      end else if (start_seen || stop_tog != stop_ack) begin
         inc_pending <= 1'b0;
      end else if (byte_done && state == DEV_AHI) begin
         addr[11:8] <= byte_in[3:0];
      end else if (byte_done && state == DEV_ALO) begin
         addr[7:0] <= byte_in;
      end else if (byte_done && state == DEV_WDATA) begin
         inc_pending <= 1'b1;
      end else if (inc_bit && state == DEV_WDATA && inc_pending) begin
         addr <= page_inc;
         inc_pending <= 1'b0;
      end else if (read_cmd || read_more) begin
         tx <= mem_rd;
         addr <= addr_inc;
      end
   end

   always_ff @(posedge bus.scl or negedge reset_n) begin
      if (!reset_n) begin
         valid <= '0;
      end else if (start_seen) begin
         valid <= '0;
      end else if (byte_done && state == DEV_WDATA) begin
         valid[addr[4:0]] <= 1'b1;
      end
   end

   always_ff @(posedge bus.scl) begin
      if (byte_done && state == DEV_WDATA) begin
         page_buf[addr[4:0]] <= byte_in;
      end
   end

   // outgoing bits change after the falling edge
   always_ff @(negedge bus.scl or negedge reset_n) begin
      if (!reset_n) begin
         oe_n <= 1'b1;
      end else if (ack_now && ack_slot) begin
         oe_n <= 1'b0;
      end else if (state == DEV_READ && !bitcnt[3]) begin
         oe_n <= tx[~bitcnt[2:0]];
      end else begin
         oe_n <= 1'b1;
      end
   end

   assign bus.dev_sda_o = 1'b0;
   assign bus.dev_sda_oe_n = oe_n;

   // ****************************************************************
   // programming, on the core clock
   // ****************************************************************
   logic [2:0] stop_sync;
   logic [1:0] wp_sync;
   logic [CW-1:0] cnt;
   logic [6:0] page;
   logic [PAGE_BYTES-1:0] sel;

   // buffer, valid bits and counter are quiet once the stop has passed
   wire stop_evt = stop_sync[2] ^ stop_sync[1];
   wire prog_go = stop_evt && |valid && !wp_sync[1] && !prog_busy;
   wire in_steps = cnt < CW'(2 * PAGE_BYTES);
   wire [4:0] slot = cnt[4:0];
   wire prog_end = cnt == CW'(PROG_CYCLES_P - 1);

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         stop_sync <= 3'h0;
         wp_sync <= 2'h0;
      end else begin
         stop_sync <= {stop_sync[1:0], stop_tog};
         wp_sync <= {wp_sync[0], write_protect};
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         prog_busy <= 1'b0;
         cnt <= '0;
         page <= 7'h00;
         sel <= '0;
      end else if (prog_go) begin
         prog_busy <= 1'b1;
         cnt <= '0;
         page <= addr[11:5];
         sel <= valid;
      end else if (prog_busy) begin
         cnt <= cnt + CW'(1);
         if (prog_end) begin
            prog_busy <= 1'b0;
         end
      end
   end

   // first pass erases the selected bytes, second pass writes them
   always_ff @(posedge core_clk) begin
      if (prog_busy && in_steps && sel[slot]) begin
         mem[{page, slot}] <= cnt[5] ? page_buf[slot] : ERASED_BYTE;
      end
   end

endmodule

// >>> hdl/seeb_pkg.sv
// ****************************************************************
// shared constants and types
// ****************************************************************
package seeb_pkg;

   localparam int ADDR_W = 12;
   localparam int MEM_BYTES = 4096;
   localparam int PAGE_BYTES = 32;
   localparam int PAGE_W = 5;
   // device-type code in the top command nibble; the value is arbitrary
   localparam logic [3:0] DEV_TYPE_CODE = 4'h6;
   localparam logic [7:0] ERASED_BYTE = 8'hff;
   localparam logic [ADDR_W-1:0] ADDR_RST = 12'h000;
   localparam logic [3:0] ACK_SLOT = 4'h8;
   localparam logic [3:0] LAST_DATA_BIT = 4'h7;

   // timing
   localparam int CORE_PERIOD_NS = 20;
   localparam int PROG_TIME_NS = 8_000_000;
   // longest time, so round down
   localparam int PROG_CYCLES = PROG_TIME_NS / CORE_PERIOD_NS;
   localparam int SCL_QTR_CYCLES = 32;

   // host command codes
   localparam logic [1:0] OP_START = 2'h0;
   localparam logic [1:0] OP_STOP = 2'h1;
   localparam logic [1:0] OP_WRITE = 2'h2;
   localparam logic [1:0] OP_READ = 2'h3;

   typedef enum logic [5:0] {
      DEV_CMD = 6'h01,
      DEV_AHI = 6'h02,
      DEV_ALO = 6'h04,
      DEV_WDATA = 6'h08,
      DEV_READ = 6'h10,
      DEV_IGNORE = 6'h20
   } seeb_dev_state_e;

   typedef enum logic [3:0] {
      HST_IDLE = 4'h1,
      HST_START = 4'h2,
      HST_BITS = 4'h4,
      HST_STOP = 4'h8
   } seeb_host_state_e;

endpackage

// >>> hdl/seeb_bus_if.sv
// ****************************************************************
// two-wire bus: open-drain data resolved as a wired and
// ****************************************************************
interface seeb_bus_if;
   logic scl;
   logic host_sda_o;
   logic host_sda_oe_n;
   logic dev_sda_o;
   logic dev_sda_oe_n;
   logic sda;

   // released line reads high through the pull-up
   assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

   modport host(output scl, output host_sda_o, output host_sda_oe_n, input sda);
   modport dev(input scl, input sda, output dev_sda_o, output dev_sda_oe_n);
endinterface

// >>> hdl/seeb_host.sv
// ****************************************************************
// bus master: byte engine driving the serial clock
// ****************************************************************
module seeb_host
   import seeb_pkg::*;
#(
   parameter int QTR_P = SCL_QTR_CYCLES
) (
   input wire logic core_clk, // system clock
   input wire logic reset_n, // async reset, active low
   input wire logic cmd_valid, // command offered
   output logic cmd_ready, // engine idle, command taken
   input wire logic [1:0] cmd_op, // start, stop, write or read
   input wire logic [7:0] cmd_data, // byte to write
   input wire logic cmd_send_ack, // read: acknowledge the byte
   output logic rsp_valid, // command finished, one cycle
   output logic [7:0] rsp_data, // byte read
   output logic rsp_ack, // ninth bit was low
   seeb_bus_if.host bus // two-wire bus
);

   seeb_host_state_e state;
   logic [15:0] qcnt;
   logic [1:0] phase;
   logic [3:0] bits;
   logic [8:0] txw;
   logic [8:0] rxw;
   logic scl_q;
   logic oe_n;
   logic [1:0] sda_sync;

   wire tick = qcnt == 16'h0000;
   wire ph_end = tick && phase == 2'h3;
   wire bits_end = ph_end && state == HST_BITS && bits == ACK_SLOT;
   wire done = bits_end || (ph_end && (state == HST_START || state == HST_STOP));

   assign cmd_ready = state == HST_IDLE;
   assign bus.scl = scl_q;
   assign bus.host_sda_o = 1'b0;
   assign bus.host_sda_oe_n = oe_n;

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         sda_sync <= 2'h3;
      end else begin
         sda_sync <= {sda_sync[0], bus.sda};
      end
   end

   // ****************************************************************
   // sequencing: four quarter periods per bit
   // ****************************************************************
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state <= HST_IDLE;
         qcnt <= 16'h0000;
         phase <= 2'h0;
         bits <= 4'h0;
         txw <= 9'h1ff;
      end else if (state == HST_IDLE) begin
         qcnt <= 16'(QTR_P - 1);
         phase <= 2'h0;
         bits <= 4'h0;
         if (cmd_valid) begin
            unique case (cmd_op)
               OP_START: state <= HST_START;
               OP_STOP: state <= HST_STOP;
               OP_WRITE: begin
                  state <= HST_BITS;
                  txw <= {cmd_data, 1'b1};
               end
               default: begin
                  state <= HST_BITS;
                  txw <= {8'hff, ~cmd_send_ack};
               end
            endcase
         end
      end else if (tick) begin
         qcnt <= 16'(QTR_P - 1);
         phase <= phase + 2'h1;
         if (state == HST_BITS && phase == 2'h3) begin
            bits <= bits + 4'h1;
            txw <= {txw[7:0], 1'b1};
         end
         if (done) begin
            state <= HST_IDLE;
         end
      end else begin
         qcnt <= qcnt - 16'h0001;
      end
   end

   // ****************************************************************
   // pin levels
   // ****************************************************************
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         scl_q <= 1'b1;
         oe_n <= 1'b1;
         rxw <= 9'h000;
      end else if (tick && state != HST_IDLE) begin
         unique case (phase)
            2'h0: begin
               scl_q <= 1'b0;
               // bit data changes only while the clock is low
               oe_n <= state == HST_BITS ? txw[8] : state != HST_STOP;
            end
            2'h1: scl_q <= 1'b1;
            2'h2: begin
               if (state == HST_BITS) begin
                  rxw <= {rxw[7:0], sda_sync[1]};
               end else begin
                  oe_n <= state == HST_STOP;
               end
            end
            default: scl_q <= state == HST_STOP;
         endcase
      end
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         rsp_valid <= 1'b0;
         rsp_data <= 8'h00;
         rsp_ack <= 1'b0;
      end else begin
         rsp_valid <= done;
         if (bits_end) begin
            rsp_data <= rxw[8:1];
            rsp_ack <= ~rxw[0];
         end
      end
   end

endmodule

// >>> sim/seeb_assertions.sv
// ****************************************************************
// link and programming timing checks
// ****************************************************************
module seeb_assertions
   import seeb_pkg::*;
#(
   parameter int PROG_CYCLES_P = PROG_CYCLES
) (
   input wire logic core_clk, // system clock
   input wire logic reset_n, // async reset, active low
   input wire logic scl, // serial clock
   input wire logic sda, // resolved data line
   input wire logic dev_sda_oe_n, // device pulls low when 0
   input wire logic write_protect, // blocks programming
   input wire logic prog_busy // erase/write running
);
   timeunit 1ns;
   timeprecision 1ps;
   logic last_scl;
   logic last_sda;
   int busy_cnt;
   int since_stop;
   wire stop_ev = scl && last_scl && sda && !last_sda;
   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   sequence s_stop;
      scl && last_scl && sda && !last_sda;
   endsequence
   sequence s_busy_on;
      $rose(prog_busy);
   endsequence
   // saturate so a long idle stretch cannot wrap back into range
   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         last_scl <= 1'b1;
         last_sda <= 1'b1;
         busy_cnt <= 0;
         since_stop <= 99;
      end else begin
         last_scl <= scl;
         last_sda <= sda;
         busy_cnt <= prog_busy ? busy_cnt + 1 : 0;
         since_stop <= stop_ev ? 0 : (since_stop < 99 ? since_stop + 1 : 99);
      end
   end
   a_dev_hold_high: assert property (scl && last_scl |-> $stable(dev_sda_oe_n))
      else $error("device data moved while clock high");
   a_dev_change_low: assert property ($changed(dev_sda_oe_n) |-> !scl)
      else $error("device data moved outside clock low");
   a_busy_after_stop: assert property (s_busy_on |-> since_stop <= 3)
      else $error("programming began without a recent stop");
   a_busy_length:
      assert property ($fell(prog_busy) |-> busy_cnt inside {[64:PROG_CYCLES_P]})
      else $error("programming cycle length out of range");
   a_busy_bounded: assert property (prog_busy |-> busy_cnt < PROG_CYCLES_P)
      else $error("programming cycle overran");
   a_busy_no_ack: assert property (prog_busy |-> dev_sda_oe_n)
      else $error("device drove data while programming");
   a_stop_standby: assert property (s_stop |=> (scl && sda) [*8])
      else $error("bus not idle after stop");
   a_wp_no_prog: assert property (s_busy_on |-> !$past(write_protect, 3))
      else $error("programming while write protected");
endmodule

// >>> sim/tb.sv
// ****************************************************************
// bench: host and device joined over one bus
// ****************************************************************
module tb
   import seeb_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic core_clk = 1'b0;
   logic reset_n = 1'b1;
   logic cmd_valid = 1'b0;
   logic cmd_send_ack = 1'b0;
   logic write_protect = 1'b0;
   logic [1:0] cmd_op = OP_START;
   logic [7:0] cmd_data = 8'h00;
   logic [2:0] straps = 3'h5;
   logic cmd_ready;
   logic rsp_valid;
   logic rsp_ack;
   logic prog_busy;
   logic [7:0] rsp_data;
   int bad_count = 0;
   int n_checks = 0;
   int cyc = 0;
   localparam logic [7:0] CMD_W = {DEV_TYPE_CODE, 3'h5, 1'b0};
   always #10 core_clk = ~core_clk;
   seeb_bus_if bus ();
   seeb_host #(.QTR_P(4)) u_seeb_host (.core_clk(core_clk), .reset_n(reset_n),
      .cmd_valid(cmd_valid), .cmd_ready(cmd_ready), .cmd_op(cmd_op), .cmd_data(cmd_data),
      .cmd_send_ack(cmd_send_ack), .rsp_valid(rsp_valid), .rsp_data(rsp_data),
      .rsp_ack(rsp_ack), .bus(bus));
   // busy lasts longer than one polling frame so the refusal is seen
   seeb_device #(.PROG_CYCLES_P(400)) u_seeb_device (.core_clk(core_clk),
      .reset_n(reset_n), .chip_select_pin_0(straps[0]), .chip_select_pin_1(straps[1]),
      .chip_select_pin_2(straps[2]), .write_protect(write_protect), .prog_busy(prog_busy),
      .bus(bus));
   seeb_assertions #(.PROG_CYCLES_P(400)) u_seeb_assertions (.core_clk(core_clk),
      .reset_n(reset_n), .scl(bus.scl), .sda(bus.sda), .dev_sda_oe_n(bus.dev_sda_oe_n),
      .write_protect(write_protect), .prog_busy(prog_busy));
   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, bad_count);
      if (bad_count == 0 && n_checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
      n_checks++;
      if (seen !== exp) begin
         bad_count++;
         $display("[ERR] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   task automatic xfer(input logic [1:0] op, input logic [7:0] d, input logic a);
      int n;
      n = 0;
      @(posedge core_clk);
      cmd_valid <= 1'b1;
      cmd_op <= op;
      cmd_data <= d;
      cmd_send_ack <= a;
      do @(negedge core_clk); while (cmd_ready !== 1'b1);
      @(posedge core_clk);
      cmd_valid <= 1'b0;
      do begin
         @(negedge core_clk);
         n++;
      end while (rsp_valid !== 1'b1 && n < 200);
      check("done", {7'h00, rsp_valid}, 8'h01);
   endtask
   task automatic wbyte(input logic [7:0] d, input logic exp);
      xfer(OP_WRITE, d, 1'b0);
      check("ack", {7'h00, rsp_ack}, {7'h00, exp});
   endtask
   task automatic addr_phase(input logic [11:0] a);
      xfer(OP_START, 8'h00, 1'b0);
      wbyte(CMD_W, 1'b1);
      wbyte({4'h0, a[11:8]}, 1'b1);
      wbyte(a[7:0], 1'b1);
   endtask
   // waits out any programming so the next frame is not refused
   task automatic settle_busy(input logic exp);
      int n;
      n = 0;
      repeat (3) @(negedge core_clk);
      check("busy", {7'h00, prog_busy}, {7'h00, exp});
      while (prog_busy === 1'b1 && n < 600) begin
         @(negedge core_clk);
         n++;
      end
      check("idle", {7'h00, prog_busy}, 8'h00);
   endtask
   task automatic rd_check(input logic [11:0] a, input logic [7:0] exp [3], input int cnt);
      addr_phase(a);
      xfer(OP_START, 8'h00, 1'b0);
      wbyte(CMD_W | 8'h01, 1'b1);
      for (int i = 0; i < cnt; i++) begin
         xfer(OP_READ, 8'h00, i < cnt - 1);
         check("rdata", rsp_data, exp[i]);
      end
      xfer(OP_STOP, 8'h00, 1'b0);
      settle_busy(1'b0);
   endtask
   task automatic t_select();
      logic [7:0] cmd;
      for (int i = 0; i < 12; i++) begin
         if (i < 8) begin
            cmd = {DEV_TYPE_CODE, 3'(i), 1'b0};
         end else begin
            cmd = {DEV_TYPE_CODE ^ (4'h1 << (i - 8)), straps, 1'b0};
         end
         xfer(OP_START, 8'h00, 1'b0);
         wbyte(cmd, (i < 8) && (3'(i) == straps));
         xfer(OP_STOP, 8'h00, 1'b0);
      end
      settle_busy(1'b0);
      $display("t_select done");
   endtask
   task automatic t_write();
      addr_phase(12'h11d);
      wbyte(8'h5a, 1'b1);
      xfer(OP_STOP, 8'h00, 1'b0);
      settle_busy(1'b1);
      addr_phase(12'h11e);
      wbyte(8'ha0, 1'b1);
      wbyte(8'ha1, 1'b1);
      wbyte(8'ha2, 1'b1);
      xfer(OP_STOP, 8'h00, 1'b0);
      repeat (3) @(negedge core_clk);
      check("busy", {7'h00, prog_busy}, 8'h01);
      xfer(OP_START, 8'h00, 1'b0);
      wbyte(CMD_W, 1'b0);
      xfer(OP_STOP, 8'h00, 1'b0);
      settle_busy(1'b1);
      xfer(OP_START, 8'h00, 1'b0);
      wbyte(CMD_W, 1'b1);
      xfer(OP_STOP, 8'h00, 1'b0);
      $display("t_write done");
   endtask
   task automatic t_protect();
      @(posedge core_clk);
      write_protect <= 1'b1;
      addr_phase(12'h11d);
      wbyte(8'h33, 1'b1);
      xfer(OP_STOP, 8'h00, 1'b0);
      settle_busy(1'b0);
      // current-address read: counter still on the last entered byte, data untouched
      xfer(OP_START, 8'h00, 1'b0);
      wbyte(CMD_W | 8'h01, 1'b1);
      xfer(OP_READ, 8'h00, 1'b0);
      check("kept", rsp_data, 8'h5a);
      xfer(OP_STOP, 8'h00, 1'b0);
      @(posedge core_clk);
      write_protect <= 1'b0;
      $display("t_protect done");
   endtask
   task automatic t_read();
      rd_check(12'h11d, '{8'h5a, 8'ha0, 8'ha1}, 3);
      rd_check(12'h100, '{8'ha2, 8'h00, 8'h00}, 1);
      $display("t_read done");
   endtask
   always @(posedge core_clk) begin
      cyc++;
      if (cyc == 40000) begin
         bad_count++;
         finish_test();
      end
   end
   initial begin
      // a real falling edge, so every asynchronous reset branch runs
      reset_n <= 1'b0;
      repeat (10) @(posedge core_clk);
      reset_n <= 1'b1;
      t_select();
      t_write();
      t_protect();
      t_read();
      finish_test();
   end
endmodule
